/* inc/flash_prot_pkg.sv */
// flash block protection: geometry, request/response carriers, controller state
package flash_prot_pkg;

    //--------------------------------------------------------------
    // geometry
    //--------------------------------------------------------------
    localparam int unsigned FLASH_BYTES = 32768;
    localparam int unsigned ERASE_BYTES = 1024;
    localparam int unsigned REGION_BYTES = 2048;
    localparam int unsigned WORD_BYTES = 4;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = $clog2(FLASH_BYTES);
    localparam int unsigned WORD_ADDR_W = $clog2(FLASH_BYTES / WORD_BYTES);
    localparam int unsigned ERASE_WORDS = ERASE_BYTES / WORD_BYTES;
    localparam int unsigned UNIT_LSB = $clog2(ERASE_WORDS);
    localparam int unsigned REGION_LSB = $clog2(REGION_BYTES / WORD_BYTES);
    localparam int unsigned REGION_COUNT = FLASH_BYTES / REGION_BYTES;

    //--------------------------------------------------------------
    // values
    //--------------------------------------------------------------
    localparam logic [31:0] ERASED_WORD = 32'hFFFF_FFFF;
    localparam logic [31:0] DENY_WORD = 32'h0000_0000;
    localparam logic [7:0] UNIT_LAST = 8'hFF;

    //--------------------------------------------------------------
    // carriers
    //--------------------------------------------------------------
    typedef enum logic [2:0] {
        REQ_FETCH = 3'b000,
        REQ_DATA_RD = 3'b001,
        REQ_DEBUG_RD = 3'b010,
        REQ_PROGRAM = 3'b011,
        REQ_ERASE = 3'b100
    } req_kind_e;

    typedef struct packed {
        req_kind_e kind;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } req_s;

    typedef struct packed {
        logic [DATA_W-1:0] rdata;
        logic err;
    } resp_s;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RD = 3'b001,
        ST_CAP = 3'b010,
        ST_PROG = 3'b011,
        ST_ERASE = 3'b100
    } ctl_state_e;

    typedef struct packed {
        ctl_state_e state;
        logic req_ready;
        logic resp_valid;
        resp_s resp;
        logic arr_rd;
        logic arr_wr;
        logic [WORD_ADDR_W-1:0] arr_addr;
        logic [DATA_W-1:0] arr_wdata;
    } ctl_s;

    localparam ctl_s CTL_RESET = '{
        state: ST_IDLE,
        req_ready: 1'b1,
        resp_valid: 1'b0,
        resp: '{rdata: 32'h0000_0000, err: 1'b0},
        arr_rd: 1'b0,
        arr_wr: 1'b0,
        arr_addr: 13'h0000,
        arr_wdata: 32'h0000_0000
    };

endpackage

/* verilog/flash_region_check.sv */
// per-region protection lookup for one flash request
`timescale 1ns/1ps
module flash_region_check #(
    parameter int unsigned REGIONS = flash_prot_pkg::REGION_COUNT
) (
    input wire flash_prot_pkg::req_kind_e kind, // request kind
    input wire logic [flash_prot_pkg::WORD_ADDR_W-1:0] word_addr, // word address
    input wire logic [REGIONS-1:0] ro_region, // read-only region mask
    input wire logic [REGIONS-1:0] xo_region, // execute-only region mask
    output logic deny // request refused by protection
);
    logic [REGIONS-1:0] hit;
    logic [REGIONS-1:0] deny_per;
    logic is_write;
    logic is_data_rd;

    assign is_write = (kind == flash_prot_pkg::REQ_PROGRAM) || (kind == flash_prot_pkg::REQ_ERASE);
    assign is_data_rd = (kind == flash_prot_pkg::REQ_DATA_RD)
        || (kind == flash_prot_pkg::REQ_DEBUG_RD);

    //--------------------------------------------------------------
    // each 2-KB region judged on its own bits only
    //--------------------------------------------------------------
    for (genvar r = 0; r < REGIONS; r++)
    begin : g_region
        assign hit[r] = (word_addr[flash_prot_pkg::WORD_ADDR_W-1:flash_prot_pkg::REGION_LSB]
            == ($bits(word_addr) - flash_prot_pkg::REGION_LSB)'(r));
        assign deny_per[r] = hit[r]
            && ((is_write && (ro_region[r] || xo_region[r]))
            || (is_data_rd && xo_region[r]));
    end

    assign deny = |deny_per;
endmodule // flash_region_check

/* verilog/flash_block_protection.sv */
// flash controller front end: block erase, program, reads, region protection
//
// Operation
// - The controller manages a 32-KB nonvolatile array.
// - Erase works on 1-KB units, each erased without touching others.
// - A finished erase leaves every bit of the unit at one.
// - Protection is per 2-KB region of two units, set independently.
// - Read-only regions refuse all erase and program requests.
// - Execute-only regions also refuse all erase and program requests.
// - Execute-only regions serve instruction fetches only; data and debug reads denied.
`timescale 1ns/1ps
module flash_block_protection #(
    parameter int unsigned REGIONS = flash_prot_pkg::REGION_COUNT
) (
    input wire logic sys_clk, // system clock, 20 MHz
    input wire logic rst, // async reset, active high
    input wire logic req_valid, // request offered
    input wire flash_prot_pkg::req_s req, // request kind, byte address, data
    output logic req_ready, // request can be taken
    output logic resp_valid, // one-cycle answer strobe
    output flash_prot_pkg::resp_s resp, // answer data and error flag
    input wire logic [REGIONS-1:0] ro_region, // read-only mask per region
    input wire logic [REGIONS-1:0] xo_region, // execute-only mask per region
    output logic [flash_prot_pkg::WORD_ADDR_W-1:0] arr_addr, // array word address
    output logic arr_rd, // array read strobe
    output logic arr_wr, // array write strobe
    output logic [flash_prot_pkg::DATA_W-1:0] arr_wdata, // array write data
    input wire logic [flash_prot_pkg::DATA_W-1:0] arr_rdata // array data, one cycle after rd
);
    flash_prot_pkg::ctl_s cur;
    flash_prot_pkg::ctl_s next_ctl;
    logic accept;
    logic deny;
    logic [flash_prot_pkg::WORD_ADDR_W-1:0] word_addr;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    assign accept = req_valid && cur.req_ready;
    assign word_addr = req.addr[flash_prot_pkg::ADDR_W-1:2];

    //--------------------------------------------------------------
    // protection lookup
    //--------------------------------------------------------------
    flash_region_check #(
        .REGIONS(REGIONS)
    ) u_check (
        .kind(req.kind),
        .word_addr(word_addr),
        .ro_region(ro_region),
        .xo_region(xo_region),
        .deny(deny)
    );

    //--------------------------------------------------------------
    // controller next state
    //--------------------------------------------------------------
    always_comb
    begin
        next_ctl = cur;
        next_ctl.resp_valid = 1'b0;
        next_ctl.arr_rd = 1'b0;
        next_ctl.arr_wr = 1'b0;
        case (cur.state)
            flash_prot_pkg::ST_IDLE:
            begin
                if (accept && deny)
                begin
                    // refused: no array access at all
                    next_ctl.resp_valid = 1'b1;
                    next_ctl.resp.rdata = flash_prot_pkg::DENY_WORD;
                    next_ctl.resp.err = 1'b1;
                end
                else if (accept && (req.kind == flash_prot_pkg::REQ_PROGRAM))
                begin
                    next_ctl.state = flash_prot_pkg::ST_PROG;
                    next_ctl.arr_wr = 1'b1;
                    next_ctl.arr_addr = word_addr;
                    next_ctl.arr_wdata = req.wdata;
                end
                else if (accept && (req.kind == flash_prot_pkg::REQ_ERASE))
                begin
                    next_ctl.state = flash_prot_pkg::ST_ERASE;
                    next_ctl.arr_wr = 1'b1;
                    next_ctl.arr_addr = {word_addr[flash_prot_pkg::WORD_ADDR_W-1:
                        flash_prot_pkg::UNIT_LSB], 8'h00};
                    next_ctl.arr_wdata = flash_prot_pkg::ERASED_WORD;
                end
                else if (accept)
                begin
                    next_ctl.state = flash_prot_pkg::ST_RD;
                    next_ctl.arr_rd = 1'b1;
                    next_ctl.arr_addr = word_addr;
                end
            end
            flash_prot_pkg::ST_RD:
            begin
                next_ctl.state = flash_prot_pkg::ST_CAP;
            end
            flash_prot_pkg::ST_CAP:
            begin
                next_ctl.state = flash_prot_pkg::ST_IDLE;
                next_ctl.resp_valid = 1'b1;
                next_ctl.resp.rdata = arr_rdata;
                next_ctl.resp.err = 1'b0;
            end
            flash_prot_pkg::ST_PROG:
            begin
                next_ctl.state = flash_prot_pkg::ST_IDLE;
                next_ctl.resp_valid = 1'b1;
                next_ctl.resp.rdata = flash_prot_pkg::DENY_WORD;
                next_ctl.resp.err = 1'b0;
            end
            flash_prot_pkg::ST_ERASE:
            begin
                // walk the unit's words; upper address bits stay fixed
                if (cur.arr_addr[flash_prot_pkg::UNIT_LSB-1:0] == flash_prot_pkg::UNIT_LAST)
                begin
                    next_ctl.state = flash_prot_pkg::ST_IDLE;
                    next_ctl.resp_valid = 1'b1;
                    next_ctl.resp.rdata = flash_prot_pkg::DENY_WORD;
                    next_ctl.resp.err = 1'b0;
                end
                else
                begin
                    next_ctl.arr_wr = 1'b1;
                    next_ctl.arr_addr[flash_prot_pkg::UNIT_LSB-1:0] =
                        cur.arr_addr[flash_prot_pkg::UNIT_LSB-1:0] + 8'h01;
                end
            end
            default:
            begin
                next_ctl.state = flash_prot_pkg::ST_IDLE;
            end
        endcase
        next_ctl.req_ready = (next_ctl.state == flash_prot_pkg::ST_IDLE);
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            cur <= flash_prot_pkg::CTL_RESET;
        else
            cur <= next_ctl;
    end

    assign req_ready = cur.req_ready;
    assign resp_valid = cur.resp_valid;
    assign resp = cur.resp;
    assign arr_addr = cur.arr_addr;
    assign arr_rd = cur.arr_rd;
    assign arr_wr = cur.arr_wr;
    assign arr_wdata = cur.arr_wdata;

    //--------------------------------------------------------------
    // checks
    //--------------------------------------------------------------
    logic [REGIONS-1:0] req_region;
    logic is_wr_req;
    logic is_dat_req;
    logic in_ro;
    logic in_xo;
    assign req_region = REGIONS'(1) << word_addr[flash_prot_pkg::WORD_ADDR_W-1:
        flash_prot_pkg::REGION_LSB];
    assign in_ro = |(req_region & ro_region);
    assign in_xo = |(req_region & xo_region);
    assign is_wr_req = (req.kind == flash_prot_pkg::REQ_PROGRAM)
        || (req.kind == flash_prot_pkg::REQ_ERASE);
    assign is_dat_req = (req.kind == flash_prot_pkg::REQ_DATA_RD)
        || (req.kind == flash_prot_pkg::REQ_DEBUG_RD);

    property p_read_data;
        cur.state == flash_prot_pkg::ST_CAP
            |=> resp_valid && !resp.err && (resp.rdata == $past(arr_rdata));
    endproperty
    a_read_data: assert property (p_read_data) else $error("read answer wrong");

    property p_erase_len;
        accept && (req.kind == flash_prot_pkg::REQ_ERASE) && !deny
            |=> arr_wr [*8] ##248 arr_wr ##1 !arr_wr && resp_valid && !resp.err;
    endproperty
    a_erase_len: assert property (p_erase_len) else $error("erase length wrong");

    property p_erase_unit;
        arr_wr && $past(arr_wr) && (cur.state == flash_prot_pkg::ST_ERASE)
            |-> $stable(arr_addr[flash_prot_pkg::WORD_ADDR_W-1:flash_prot_pkg::UNIT_LSB]);
    endproperty
    a_erase_unit: assert property (p_erase_unit) else $error("erase left its unit");

    property p_erase_ones;
        arr_wr && (cur.state == flash_prot_pkg::ST_ERASE)
            |-> arr_wdata == flash_prot_pkg::ERASED_WORD;
    endproperty
    a_erase_ones: assert property (p_erase_ones) else $error("erase data not ones");

    property p_region_free;
        accept && !in_ro && !in_xo |=> !(resp_valid && resp.err);
    endproperty
    a_region_free: assert property (p_region_free) else $error("open region denied");

    property p_ro_block;
        accept && is_wr_req && in_ro |=> !arr_wr ##1 !arr_wr;
    endproperty
    a_ro_block: assert property (p_ro_block) else $error("read-only write went out");

    property p_xo_block;
        accept && is_wr_req && in_xo |=> !arr_wr && resp_valid && resp.err;
    endproperty
    a_xo_block: assert property (p_xo_block) else $error("exec-only write went out");

    property p_xo_read;
        accept && is_dat_req && in_xo |=> !arr_rd && resp_valid && resp.err;
    endproperty
    a_xo_read: assert property (p_xo_read) else $error("exec-only data read served");

    property p_fetch_ok;
        accept && (req.kind == flash_prot_pkg::REQ_FETCH)
            |=> arr_rd ##2 resp_valid && !resp.err;
    endproperty
    a_fetch_ok: assert property (p_fetch_ok) else $error("fetch not served");

    property p_deny_value;
        accept && deny |=> resp_valid && resp.err && (resp.rdata == flash_prot_pkg::DENY_WORD);
    endproperty
    a_deny_value: assert property (p_deny_value) else $error("deny answer wrong");

    c_erase: cover property (accept && (req.kind == flash_prot_pkg::REQ_ERASE) && !deny);
    c_xo_fetch: cover property (accept && (req.kind == flash_prot_pkg::REQ_FETCH) && in_xo);
    c_debug_deny: cover property (accept && (req.kind == flash_prot_pkg::REQ_DEBUG_RD) && deny);
    c_program: cover property (accept && (req.kind == flash_prot_pkg::REQ_PROGRAM) && !deny);
endmodule // flash_block_protection

/* verif/flash_array_model.sv */
// behavioural flash array: word storage with one-cycle synchronous read
`timescale 1ns/1ps
module flash_array_model (
    input wire logic sys_clk, // system clock
    input wire logic [flash_prot_pkg::WORD_ADDR_W-1:0] arr_addr, // word address
    input wire logic arr_rd, // read strobe
    input wire logic arr_wr, // write strobe
    input wire logic [flash_prot_pkg::DATA_W-1:0] arr_wdata, // write data
    output logic [flash_prot_pkg::DATA_W-1:0] arr_rdata // read data, cycle after strobe
);
    //----------------------------------------------------------------
    // storage
    //----------------------------------------------------------------
    logic [31:0] mem [8192];

    initial
    begin
        for (int i = 0; i < 8192; i++)
            mem[i] = 32'h5A00_0000 | 32'(i);
        arr_rdata = 32'hFFFF_FFFF;
    end

    always @(posedge sys_clk)
    begin
        if (arr_wr === 1'b1)
            mem[arr_addr] <= arr_wdata;
        if (arr_rd === 1'b1)
            arr_rdata <= mem[arr_addr];
        else
            arr_rdata <= ~arr_rdata; // no stale data outside the read slot
    end
endmodule // flash_array_model

/* verif/flash_block_protection_tb.sv */
// self-checking bench for the flash block protection controller
`timescale 1ns/1ps
module flash_block_protection_tb;
    typedef struct packed {
        flash_prot_pkg::req_kind_e kind;
        logic [14:0] addr;
        logic [31:0] wdata;
        logic [15:0] ro;
        logic [15:0] xo;
        logic err;
        logic [31:0] rdata;
    } row_s;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    flash_prot_pkg::req_s req = '0;
    logic [15:0] ro_region = 16'h0000;
    logic [15:0] xo_region = 16'h0000;
    logic req_ready;
    logic resp_valid;
    flash_prot_pkg::resp_s resp;
    logic [12:0] arr_addr;
    logic arr_rd;
    logic arr_wr;
    logic [31:0] arr_wdata;
    logic [31:0] arr_rdata;
    int err_count = 0;
    int n_checks = 0;
    int cycles = 0;
    row_s rows [14] = '{
        '{flash_prot_pkg::REQ_FETCH, 15'h0000, 32'h0, 16'h0, 16'h0, 1'b0, 32'h5A00_0000},
        '{flash_prot_pkg::REQ_DATA_RD, 15'h0804, 32'h0, 16'h0, 16'h0, 1'b0, 32'h5A00_0201},
        '{flash_prot_pkg::REQ_DEBUG_RD, 15'h1000, 32'h0, 16'h0, 16'h0, 1'b0, 32'h5A00_0400},
        '{flash_prot_pkg::REQ_PROGRAM, 15'h0010, 32'h1234_5678, 16'h0, 16'h0, 1'b0, 32'h0},
        '{flash_prot_pkg::REQ_DATA_RD, 15'h0010, 32'h0, 16'h0, 16'h0, 1'b0, 32'h1234_5678},
        '{flash_prot_pkg::REQ_PROGRAM, 15'h1004, 32'h0, 16'h4, 16'h0, 1'b1, 32'h0},
        '{flash_prot_pkg::REQ_ERASE, 15'h1004, 32'h0, 16'h4, 16'h0, 1'b1, 32'h0},
        '{flash_prot_pkg::REQ_PROGRAM, 15'h1800, 32'h0, 16'h0, 16'h8, 1'b1, 32'h0},
        '{flash_prot_pkg::REQ_ERASE, 15'h1800, 32'h0, 16'h0, 16'h8, 1'b1, 32'h0},
        '{flash_prot_pkg::REQ_DATA_RD, 15'h1800, 32'h0, 16'h0, 16'h8, 1'b1, 32'h0},
        '{flash_prot_pkg::REQ_DEBUG_RD, 15'h1800, 32'h0, 16'h0, 16'h8, 1'b1, 32'h0},
        '{flash_prot_pkg::REQ_FETCH, 15'h1800, 32'h0, 16'h0, 16'h8, 1'b0, 32'h5A00_0600},
        '{flash_prot_pkg::REQ_DATA_RD, 15'h1004, 32'h0, 16'h4, 16'h0, 1'b0, 32'h5A00_0401},
        '{flash_prot_pkg::REQ_DATA_RD, 15'h1800, 32'h0, 16'h8, 16'h8, 1'b1, 32'h0}
    };
    logic [14:0] ea [4] = '{15'h1400, 15'h17FC, 15'h13FC, 15'h1800};
    logic [31:0] ed [4] = '{32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h5A00_04FF, 32'h5A00_0600};
    flash_prot_pkg::resp_s r;
    int lat;
    int stb;

    flash_block_protection i_dut (
        .sys_clk(sys_clk),
        .rst(rst),
        .req_valid(req_valid),
        .req(req),
        .req_ready(req_ready),
        .resp_valid(resp_valid),
        .resp(resp),
        .ro_region(ro_region),
        .xo_region(xo_region),
        .arr_addr(arr_addr),
        .arr_rd(arr_rd),
        .arr_wr(arr_wr),
        .arr_wdata(arr_wdata),
        .arr_rdata(arr_rdata)
    );

    flash_array_model i_array (
        .sys_clk(sys_clk),
        .arr_addr(arr_addr),
        .arr_rd(arr_rd),
        .arr_wr(arr_wr),
        .arr_wdata(arr_wdata),
        .arr_rdata(arr_rdata)
    );

    initial
    begin
        forever #25 sys_clk = ~sys_clk;
    end

    //----------------------------------------------------------------
    // shared tasks
    //----------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic do_req(input flash_prot_pkg::req_kind_e k, input logic [14:0] a,
            input logic [31:0] d, input logic [15:0] m_ro, input logic [15:0] m_xo);
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req <= '{kind: k, addr: a, wdata: d};
        ro_region <= m_ro;
        xo_region <= m_xo;
        do @(posedge sys_clk); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        // cycle 1 after the taking edge is the first one looked at
        #1;
        lat = 1;
        stb = int'(arr_rd === 1'b1 || arr_wr === 1'b1);
        while (resp_valid !== 1'b1 && lat < 400)
        begin
            @(posedge sys_clk);
            #1;
            lat++;
            stb += int'(arr_rd === 1'b1 || arr_wr === 1'b1);
        end
        r = resp;
    endtask

    function automatic int exp_lat(input flash_prot_pkg::req_kind_e k, input logic e);
        if (e)
            return 1;
        if (k == flash_prot_pkg::REQ_PROGRAM)
            return 2;
        if (k == flash_prot_pkg::REQ_ERASE)
            return 257;
        return 3;
    endfunction

    task results;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            err_count++;
            results();
        end
    end

    //----------------------------------------------------------------
    // main sequence
    //----------------------------------------------------------------
    initial
    begin
        @(posedge sys_clk);
        #1;
        check("ready in reset", 32'(req_ready), 32'h1);
        check("strobes in reset", {resp_valid, arr_rd, arr_wr}, 32'h0);
        @(posedge sys_clk);
        rst <= 1'b0;
        $display("test reset done");
        for (int i = 0; i < 14; i++)
        begin
            do_req(rows[i].kind, rows[i].addr, rows[i].wdata, rows[i].ro, rows[i].xo);
            check("err", 32'(r.err), 32'(rows[i].err));
            check("rdata", r.rdata, rows[i].rdata);
            check("latency", lat, exp_lat(rows[i].kind, rows[i].err));
            check("array strobes", stb, rows[i].err ? 0 : 1);
            check("ready", 32'(req_ready), 32'h1);
        end
        $display("test rows done");
        // erase the upper unit of an open region, then look around its edges
        do_req(flash_prot_pkg::REQ_ERASE, 15'h1404, 32'h0, 16'h0008, 16'h0000);
        check("erase err", 32'(r.err), 32'h0);
        check("erase latency", lat, 32'h0000_0101);
        check("erase strobes", stb, 32'h0000_0100);
        for (int i = 0; i < 4; i++)
        begin
            do_req(flash_prot_pkg::REQ_DATA_RD, ea[i], 32'h0, 16'h0, 16'h0);
            check("after erase", r.rdata, ed[i]);
        end
        $display("test erase done");
        // cut an erase short by reset, then look at the controller and the array
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req <= '{kind: flash_prot_pkg::REQ_ERASE, addr: 15'h0400, wdata: 32'h0};
        do @(posedge sys_clk); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b1;
        #1;
        check("cut strobes", {resp_valid, arr_rd, arr_wr}, 32'h0);
        check("cut ready", 32'(req_ready), 32'h1);
        check("cut addr", 32'(arr_addr), 32'h0);
        @(posedge sys_clk);
        @(posedge sys_clk);
        rst <= 1'b0;
        do_req(flash_prot_pkg::REQ_DATA_RD, 15'h0400, 32'h0, 16'h0, 16'h0);
        check("cut erase first word", r.rdata, 32'hFFFF_FFFF);
        do_req(flash_prot_pkg::REQ_DATA_RD, 15'h0500, 32'h0, 16'h0, 16'h0);
        check("cut erase stopped", r.rdata, 32'h5A00_0140);
        check("cut erase latency", lat, 32'h3);
        $display("test midrun reset done");
        results();
    end
endmodule // flash_block_protection_tb
